/* adc_cmp_pkg.sv */
package adc_cmp_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_RESULT_LOW     = 8'hc2;
    localparam logic [7:0] IDX_RESULT_HIGH    = 8'hc3;
    localparam logic [7:0] IDX_THRESH_LOW     = 8'hce;
    localparam logic [7:0] IDX_THRESH_HIGH    = 8'hcf;
    localparam logic [7:0] IDX_IRQ_STATUS     = 8'hd0;
    localparam logic [7:0] IDX_IRQ_MASK       = 8'hd1;
    localparam logic [7:0] IDX_CMP_DLY_CTRL   = 8'he2;
    localparam logic [7:0] IDX_DELAY_LOW      = 8'he3;
    localparam logic [7:0] IDX_PIN_DISCONNECT = 8'hf6;

    // compare_and_delay_control fields
    localparam int BIT_BRAKE_EN  = 7;
    localparam int BIT_POLARITY  = 6;
    localparam int BIT_CMP_EN    = 5;
    localparam int BIT_CMP_OUT   = 4;
    localparam int BIT_DELAY_MSB = 0;

    // interrupt event bits
    localparam int EVT_CONV_DONE = 0;
    localparam int EVT_CMP_HIT   = 1;
    localparam int EVT_BRAKE     = 2;
    localparam int EVT_COUNT     = 3;

    localparam logic [7:0]  REG_RESET   = 8'h00;
    localparam logic [11:0] WORD_RESET  = 12'h000;
    localparam logic [8:0]  DELAY_RESET = 9'h000;
    localparam logic [2:0]  EVT_RESET   = 3'h0;

    typedef enum logic {
        TRIG_IDLE,
        TRIG_WAIT
    } trig_state_t;

endpackage

/* adc_result_compare_delay.sv */
// Overview of operation
// - enabled brake linkage asserts pwm fault brake when comparator output is one
// - compare brake pulses a clear of pwm run; resume waits for software run
// - polarity 0: result >= threshold gives one; polarity 1: result below threshold
// - comparator works only while its enable bit is one
// - comparator output is read only, refreshed at every conversion completion
// - trigger delay is nine bits: delay register plus control bit 0
// - after an external trigger wait the programmed delay, then start conversion
// - result high byte reads result bits 11 to 4, read only
// - result low byte reads result bits 3 to 0, upper bits reserved
// - threshold held in high byte 11:4 and low nibble 3:0, read/write
// - disconnect bit one forces that channel digital input to read zero
// - all registers clear to zero on reset
// - delay applies only when external trigger enable is one
//
// Design decision made here: the APB register port.
`timescale 1ns/100ps
`default_nettype none

module adc_result_compare_delay
    import adc_cmp_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [9:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic             pslverr,
    output logic      [31:0] prdata,
    input  wire logic        conv_done,
    input  wire logic [11:0] conv_data,
    input  wire logic        conv_busy,
    input  wire logic        sw_start,
    input  wire logic        external_trigger_enable,
    input  wire logic        ext_trigger,
    output logic             conv_start,
    output logic             fault_brake,
    output logic             pwm_run_clear,
    input  wire logic        pwm_run_set,
    input  wire logic [7:0]  pin_in,
    output logic      [7:0]  pin_digital_in,
    output logic             irq
);

    ////////////////////////////////////////////////////////////////////////////
    // bus decode

    logic [11:0]          conversion_result_r;
    logic [11:0]          compare_threshold_r;
    logic                 brake_on_compare_enable_r;
    logic                 compare_polarity_select_r;
    logic                 result_comparator_enable_r;
    logic                 comparator_output_r;
    logic [8:0]           trigger_delay_count_r;
    logic [7:0]           channel_digital_input_disable_r;
    logic [EVT_COUNT-1:0] irq_status_r;
    logic [EVT_COUNT-1:0] irq_mask_r;
    logic [EVT_COUNT-1:0] evt;
    logic [8:0]           delay_cnt_r;
    trig_state_t          trig_state_r;
    logic                 cmp_nxt;
    logic                 mapped;
    logic [7:0]           rd_byte;
    logic [7:0]           idx;
    logic                 wr_en;
    logic [7:0]           wbyte;
    logic                 ext_accept;
    logic                 delay_expired;

    // every check below runs on pclk and sleeps through reset
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    assign idx   = paddr[9:2];
    assign wbyte = pwdata[7:0];
    assign pready = 1'b1;
    assign wr_en = psel && penable && pwrite && mapped;

    always_comb begin
        mapped  = 1'b1;
        rd_byte = REG_RESET;
        unique case (idx)
            IDX_RESULT_LOW:     rd_byte = {4'h0, conversion_result_r[3:0]};
            IDX_RESULT_HIGH:    rd_byte = conversion_result_r[11:4];
            IDX_THRESH_LOW:     rd_byte = {4'h0, compare_threshold_r[3:0]};
            IDX_THRESH_HIGH:    rd_byte = compare_threshold_r[11:4];
            IDX_IRQ_STATUS:     rd_byte = {5'h00, irq_status_r};
            IDX_IRQ_MASK:       rd_byte = {5'h00, irq_mask_r};
            IDX_CMP_DLY_CTRL:   rd_byte = {brake_on_compare_enable_r, compare_polarity_select_r,
                                           result_comparator_enable_r, comparator_output_r,
                                           3'h0, trigger_delay_count_r[8]};
            IDX_DELAY_LOW:      rd_byte = trigger_delay_count_r[7:0];
            IDX_PIN_DISCONNECT: rd_byte = channel_digital_input_disable_r;
            default: begin
                mapped  = 1'b0;
                rd_byte = REG_RESET;
            end
        endcase
    end

    assign pslverr = psel && penable && !mapped;

    // read data captured in setup so the access phase shows a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= {24'h00_0000, rd_byte};
        end
    end

    a_result_high_view: assert property (
        psel && penable && !pwrite && idx == IDX_RESULT_HIGH
        |-> prdata[7:0] == $past(conversion_result_r[11:4]))
        else $error("result high byte read wrong");

    a_result_low_view: assert property (
        psel && penable && !pwrite && idx == IDX_RESULT_LOW
        |-> prdata[7:0] == {4'h0, $past(conversion_result_r[3:0])})
        else $error("result low byte read wrong");

    // writes leave prdata at the last read, so only reads are judged
    a_reserved_read_zero: assert property (
        psel && penable && !pwrite && (idx == IDX_RESULT_LOW || idx == IDX_THRESH_LOW) |-> prdata[7:4] == 4'h0)
        else $error("reserved bits read nonzero");

    a_ctrl_reserved_zero: assert property (
        psel && penable && !pwrite && idx == IDX_CMP_DLY_CTRL |-> prdata[3:1] == 3'h0)
        else $error("control reserved bits read nonzero");

    ////////////////////////////////////////////////////////////////////////////
    // software registers

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            compare_threshold_r <= WORD_RESET;
        end else if (wr_en && idx == IDX_THRESH_HIGH) begin
            compare_threshold_r[11:4] <= wbyte;
        end else if (wr_en && idx == IDX_THRESH_LOW) begin
            compare_threshold_r[3:0] <= wbyte[3:0];
        end
    end

    a_thresh_high_wr: assert property (
        wr_en && idx == IDX_THRESH_HIGH |=> compare_threshold_r[11:4] == $past(wbyte))
        else $error("threshold high write lost");

    a_thresh_low_wr: assert property (
        wr_en && idx == IDX_THRESH_LOW |=> compare_threshold_r[3:0] == $past(wbyte[3:0]))
        else $error("threshold low write lost");

    // nine bit delay assembled from two registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            brake_on_compare_enable_r  <= 1'b0;
            compare_polarity_select_r  <= 1'b0;
            result_comparator_enable_r <= 1'b0;
            trigger_delay_count_r      <= DELAY_RESET;
        end else if (wr_en && idx == IDX_CMP_DLY_CTRL) begin
            brake_on_compare_enable_r  <= wbyte[BIT_BRAKE_EN];
            compare_polarity_select_r  <= wbyte[BIT_POLARITY];
            result_comparator_enable_r <= wbyte[BIT_CMP_EN];
            trigger_delay_count_r[8]   <= wbyte[BIT_DELAY_MSB];
        end else if (wr_en && idx == IDX_DELAY_LOW) begin
            trigger_delay_count_r[7:0] <= wbyte;
        end
    end

    a_delay_low_wr: assert property (
        wr_en && idx == IDX_DELAY_LOW |=> trigger_delay_count_r[7:0] == $past(wbyte))
        else $error("delay low byte write lost");

    a_delay_msb_wr: assert property (
        wr_en && idx == IDX_CMP_DLY_CTRL |=> trigger_delay_count_r[8] == $past(wbyte[BIT_DELAY_MSB]))
        else $error("delay bit eight write lost");

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            channel_digital_input_disable_r <= REG_RESET;
        end else if (wr_en && idx == IDX_PIN_DISCONNECT) begin
            channel_digital_input_disable_r <= wbyte;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_digital_in <= REG_RESET;
        end else begin
            pin_digital_in <= pin_in & ~channel_digital_input_disable_r;
        end
    end

    a_pin_forced_zero: assert property (
        1'b1 |=> (pin_digital_in & $past(channel_digital_input_disable_r)) == REG_RESET)
        else $error("disconnected pin read one");

    ////////////////////////////////////////////////////////////////////////////
    // result and comparator

    // polarity selects the sense; disabled gives zero
    always_comb begin
        cmp_nxt = 1'b0;
        if (result_comparator_enable_r) begin
            cmp_nxt = compare_polarity_select_r ? (conv_data < compare_threshold_r)
                                                : (conv_data >= compare_threshold_r);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conversion_result_r <= WORD_RESET;
            comparator_output_r <= 1'b0;
        end else if (conv_done) begin
            conversion_result_r <= conv_data;
            comparator_output_r <= cmp_nxt;
        end
    end

    a_cmp_ge_sense: assert property (
        conv_done && result_comparator_enable_r && !compare_polarity_select_r
        |=> comparator_output_r == ($past(conv_data) >= $past(compare_threshold_r)))
        else $error("comparator wrong for polarity zero");

    a_cmp_lt_sense: assert property (
        conv_done && result_comparator_enable_r && compare_polarity_select_r
        |=> comparator_output_r == ($past(conv_data) < $past(compare_threshold_r)))
        else $error("comparator wrong for polarity one");

    a_cmp_off_zero: assert property (
        conv_done && !result_comparator_enable_r |=> !comparator_output_r)
        else $error("disabled comparator gave one");

    a_cmp_out_hold: assert property (
        !conv_done |=> $stable(comparator_output_r) && $stable(conversion_result_r))
        else $error("comparator changed without conversion");

    a_result_capture: assert property (
        conv_done |=> conversion_result_r == $past(conv_data))
        else $error("result not captured at completion");

    ////////////////////////////////////////////////////////////////////////////
    // fault brake linkage

    // brake held until pwm is restarted; one-cycle run clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_brake   <= 1'b0;
            pwm_run_clear <= 1'b0;
        end else begin
            pwm_run_clear <= 1'b0;
            if (conv_done && cmp_nxt && brake_on_compare_enable_r) begin
                fault_brake   <= 1'b1;
                pwm_run_clear <= 1'b1;
            end else if (pwm_run_set) begin
                fault_brake <= 1'b0;
            end
        end
    end

    a_brake_on_hit: assert property (
        conv_done && cmp_nxt && brake_on_compare_enable_r |=> fault_brake && pwm_run_clear)
        else $error("brake not asserted on compare");

    a_no_brake_off: assert property (
        !brake_on_compare_enable_r && !fault_brake |=> !fault_brake)
        else $error("brake raised with linkage disabled");

    // the brake is a held level; the run clear is only a one-cycle kick
    a_run_clear_pulse: assert property (
        !(conv_done && cmp_nxt && brake_on_compare_enable_r) |=> !pwm_run_clear)
        else $error("run clear without compare brake");

    a_brake_held: assert property (
        fault_brake && !pwm_run_set |=> fault_brake)
        else $error("brake dropped before run restart");

    a_brake_release: assert property (
        pwm_run_set && !(conv_done && cmp_nxt && brake_on_compare_enable_r) |=> !fault_brake)
        else $error("brake not released by run restart");

    ////////////////////////////////////////////////////////////////////////////
    // trigger delay

    // external trigger counts only when enabled; busy converter ignores it
    assign ext_accept    = ext_trigger && external_trigger_enable && !conv_busy
                           && trig_state_r == TRIG_IDLE;
    assign delay_expired = trig_state_r == TRIG_WAIT && delay_cnt_r == DELAY_RESET;

    // count down the programmed delay before starting
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_state_r <= TRIG_IDLE;
            delay_cnt_r  <= DELAY_RESET;
        end else begin
            unique case (trig_state_r)
                TRIG_IDLE: begin
                    if (ext_accept) begin
                        trig_state_r <= TRIG_WAIT;
                        delay_cnt_r  <= trigger_delay_count_r;
                    end
                end
                TRIG_WAIT: begin
                    if (delay_cnt_r == DELAY_RESET) begin
                        trig_state_r <= TRIG_IDLE;
                    end else begin
                        delay_cnt_r <= delay_cnt_r - 9'h001;
                    end
                end
            endcase
        end
    end

    // software start bypasses the delay
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_start <= 1'b0;
        end else begin
            conv_start <= sw_start || delay_expired;
        end
    end

    a_delay_zero_start: assert property (
        ext_accept && trigger_delay_count_r == DELAY_RESET |=> ##1 conv_start)
        else $error("zero delay start missing");

    a_delay_wait_two: assert property (
        ext_accept && trigger_delay_count_r == 9'h002 |=> !delay_expired[*2] ##1 delay_expired)
        else $error("delay of two counted wrong");

    a_delay_load: assert property (
        ext_accept |=> delay_cnt_r == $past(trigger_delay_count_r))
        else $error("delay counter not loaded");

    a_ext_gate_off: assert property (
        trig_state_r == TRIG_IDLE && !external_trigger_enable |=> trig_state_r == TRIG_IDLE)
        else $error("delay started with trigger disabled");

    a_sw_start_direct: assert property (
        sw_start |=> conv_start)
        else $error("software start not passed on");

    ////////////////////////////////////////////////////////////////////////////
    // interrupts

    assign evt[EVT_CONV_DONE] = conv_done;
    assign evt[EVT_CMP_HIT]   = conv_done && cmp_nxt;
    assign evt[EVT_BRAKE]     = conv_done && cmp_nxt && brake_on_compare_enable_r;

    // a new event wins over a simultaneous write-one clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status_r <= EVT_RESET;
        end else if (wr_en && idx == IDX_IRQ_STATUS) begin
            irq_status_r <= (irq_status_r & ~wbyte[EVT_COUNT-1:0]) | evt;
        end else begin
            irq_status_r <= irq_status_r | evt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_r <= EVT_RESET;
        end else if (wr_en && idx == IDX_IRQ_MASK) begin
            irq_mask_r <= wbyte[EVT_COUNT-1:0];
        end
    end

    assign irq = |(irq_status_r & irq_mask_r);

    ////////////////////////////////////////////////////////////////////////////
    // interrupt checks

    // a clear that meets a new event must not lose the event
    a_status_set_wins: assert property (
        conv_done |=> irq_status_r[EVT_CONV_DONE])
        else $error("conversion event lost");

endmodule

`default_nettype wire

/* HANDOVER_unused_marker_none.sv */
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

/* conv_partner.sv */
`timescale 1ns/100ps
`default_nettype none

module conv_partner #(
    parameter int CONV_CYCLES = 5
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        conv_start,
    input  wire logic [11:0] next_value,
    input  wire logic        pwm_run_clear,
    input  wire logic        pwm_run_set,
    output logic             conv_busy,
    output logic             conv_done,
    output logic      [11:0] conv_data,
    output logic             pwm_running
);
    int          cnt;
    logic [11:0] held;

    // inverted outside done so a stale value never matches
    assign conv_data = conv_done ? held : ~held;
    assign conv_busy = (cnt != 0);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt       <= 0;
            held      <= 12'h000;
            conv_done <= 1'b0;
        end else begin
            conv_done <= (cnt == 1);
            if (conv_start) begin
                cnt  <= CONV_CYCLES;
                held <= next_value;
            end else if (cnt != 0) begin
                cnt <= cnt - 1;
            end
        end
    end

    ////////////////////////////////////////
    // pwm assumed running out of reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwm_running <= 1'b1;
        end else if (pwm_run_clear) begin
            pwm_running <= 1'b0;
        end else if (pwm_run_set) begin
            pwm_running <= 1'b1;
        end
    end
endmodule

`default_nettype wire

/* tb_adc_result_compare_delay.sv */
`timescale 1ns/100ps
`default_nettype none

module tb_adc_result_compare_delay
    import adc_cmp_pkg::*;
;
    logic        pclk = 1'b0, presetn = 1'b0;
    logic [9:0]  paddr = 10'h000;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] pwdata = 32'h00000000;
    logic        sw_start = 1'b0, ext_trigger = 1'b0;
    logic        external_trigger_enable = 1'b0, pwm_run_set = 1'b0;
    logic [7:0]  pin_in = 8'h00;
    logic [11:0] next_value = 12'h000;
    logic        pready, pslverr, conv_start, fault_brake, pwm_run_clear, irq;
    logic [31:0] prdata;
    logic [7:0]  pin_digital_in;
    logic        conv_done, conv_busy, pwm_running;
    logic [11:0] conv_data;
    int          fails = 0, total_checks = 0;

    always #12.5 pclk = ~pclk;

    adc_result_compare_delay adc_result_compare_delay_inst (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .conv_done(conv_done), .conv_data(conv_data), .conv_busy(conv_busy),
        .sw_start(sw_start), .external_trigger_enable(external_trigger_enable),
        .ext_trigger(ext_trigger), .conv_start(conv_start),
        .fault_brake(fault_brake), .pwm_run_clear(pwm_run_clear),
        .pwm_run_set(pwm_run_set), .pin_in(pin_in),
        .pin_digital_in(pin_digital_in), .irq(irq)
    );

    conv_partner conv_partner_inst (
        .pclk(pclk), .presetn(presetn), .conv_start(conv_start),
        .next_value(next_value), .pwm_run_clear(pwm_run_clear),
        .pwm_run_set(pwm_run_set), .conv_busy(conv_busy),
        .conv_done(conv_done), .conv_data(conv_data), .pwm_running(pwm_running)
    );

    ////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd,
                       output logic [7:0] rd, output logic err);
        int n;
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= {idx, 2'b00};
        pwdata <= {24'h000000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) fails++;
        rd = prdata[7:0];
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
        logic [7:0] d;
        logic       e;
        apb(1'b1, idx, wd, d, e);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [7:0] exp, input string what);
        logic [7:0] d;
        logic       e;
        apb(1'b0, idx, 8'h00, d, e);
        chk(what, {24'h000000, d}, {24'h000000, exp});
    endtask

    task automatic wait_done;
        int n;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (conv_done !== 1'b1 && n < 50);
        if (conv_done !== 1'b1) fails++;
        repeat (3) @(posedge pclk);
    endtask

    task automatic conv(input logic [11:0] v);
        next_value <= v;
        sw_start   <= 1'b1;
        @(posedge pclk);
        sw_start <= 1'b0;
        wait_done();
    endtask

    ////////////////////////////////////////
    task automatic t_reset;
        logic [7:0] idx [9] = '{IDX_RESULT_LOW, IDX_RESULT_HIGH, IDX_THRESH_LOW,
            IDX_THRESH_HIGH, IDX_IRQ_STATUS, IDX_IRQ_MASK, IDX_CMP_DLY_CTRL,
            IDX_DELAY_LOW, IDX_PIN_DISCONNECT};
        logic [7:0] d;
        logic       e;
        foreach (idx[i]) rd(idx[i], 8'h00, "reset value");
        apb(1'b0, 8'h00, 8'h00, d, e);
        chk("unmapped error", {31'h0, e}, 32'h1);
        chk("unmapped data", {24'h0, d}, 32'h0);
    endtask

    task automatic t_access;
        wr(IDX_THRESH_LOW, 8'hff);
        rd(IDX_THRESH_LOW, 8'h0f, "threshold low");
        wr(IDX_THRESH_HIGH, 8'ha5);
        rd(IDX_THRESH_HIGH, 8'ha5, "threshold high");
        wr(IDX_CMP_DLY_CTRL, 8'hff);
        rd(IDX_CMP_DLY_CTRL, 8'he1, "control bits");
        wr(IDX_RESULT_HIGH, 8'hff);
        rd(IDX_RESULT_HIGH, 8'h00, "result read only");
    endtask

    task automatic t_compare;
        logic [11:0] val [4] = '{12'h123, 12'h122, 12'h122, 12'h123};
        logic        pol [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
        logic        hit [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
        wr(IDX_THRESH_HIGH, 8'h12);
        wr(IDX_THRESH_LOW, 8'h03);
        for (int i = 0; i < 4; i++) begin
            wr(IDX_CMP_DLY_CTRL, {1'b0, pol[i], 6'h20});
            conv(val[i]);
            rd(IDX_CMP_DLY_CTRL, {1'b0, pol[i], 1'b1, hit[i], 4'h0}, "compare out");
            rd(IDX_RESULT_HIGH, val[i][11:4], "result high");
            rd(IDX_RESULT_LOW, {4'h0, val[i][3:0]}, "result low");
            chk("brake off", {31'h0, fault_brake}, 32'h0);
        end
        wr(IDX_CMP_DLY_CTRL, 8'h80);
        conv(12'hfff);
        rd(IDX_CMP_DLY_CTRL, 8'h80, "disabled compare");
        chk("disabled brake", {31'h0, fault_brake}, 32'h0);
    endtask

    task automatic t_brake;
        wr(IDX_IRQ_STATUS, 8'h07);
        wr(IDX_IRQ_MASK, 8'h04);
        wr(IDX_CMP_DLY_CTRL, 8'ha0);
        conv(12'h200);
        chk("brake on", {31'h0, fault_brake}, 32'h1);
        chk("pwm stopped", {31'h0, pwm_running}, 32'h0);
        chk("irq raised", {31'h0, irq}, 32'h1);
        rd(IDX_IRQ_STATUS, 8'h07, "status");
        wr(IDX_IRQ_STATUS, 8'h04);
        rd(IDX_IRQ_STATUS, 8'h03, "status cleared");
        chk("irq masked", {31'h0, irq}, 32'h0);
        chk("brake holds", {31'h0, fault_brake}, 32'h1);
        pwm_run_set <= 1'b1;
        @(posedge pclk);
        pwm_run_set <= 1'b0;
        repeat (3) @(posedge pclk);
        chk("brake released", {31'h0, fault_brake}, 32'h0);
        chk("pwm resumed", {31'h0, pwm_running}, 32'h1);
    endtask

    task automatic t_delay;
        logic [8:0] dly [3] = '{9'h000, 9'h002, 9'h101};
        int n;
        external_trigger_enable <= 1'b1;
        foreach (dly[i]) begin
            wr(IDX_DELAY_LOW, dly[i][7:0]);
            wr(IDX_CMP_DLY_CTRL, {7'h00, dly[i][8]});
            ext_trigger <= 1'b1;
            @(posedge pclk);
            ext_trigger <= 1'b0;
            n = 0;
            do begin
                @(posedge pclk);
                n++;
            end while (conv_start !== 1'b1 && n < 600);
            chk("trigger delay", n, dly[i] + 2);
            wait_done();
        end
        external_trigger_enable <= 1'b0;
        ext_trigger <= 1'b1;
        @(posedge pclk);
        ext_trigger <= 1'b0;
        n = 0;
        repeat (20) begin
            @(posedge pclk);
            if (conv_start !== 1'b0) n++;
        end
        chk("trigger disabled", n, 0);
    endtask

    task automatic t_pins;
        pin_in <= 8'hff;
        wr(IDX_PIN_DISCONNECT, 8'h5a);
        rd(IDX_PIN_DISCONNECT, 8'h5a, "disconnect reg");
        chk("pins", {24'h0, pin_digital_in}, 32'ha5);
        pin_in <= 8'h0f;
        repeat (2) @(posedge pclk);
        chk("pins follow", {24'h0, pin_digital_in}, 32'h05);
    endtask

    ////////////////////////////////////////
    task automatic complete_run;
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        #(25 * 20000);
        fails++;
        complete_run();
    end

    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_access();
        t_compare();
        t_brake();
        t_delay();
        t_pins();
        complete_run();
    end
endmodule

`default_nettype wire
